/* File: aci_pkg.sv */
// Package with register map, field layout and codes of the converter control.
package aci_pkg;
   // Register byte offsets.
   localparam logic [3:0] OFF_CLOCK_CONTROL = 4'h0;
   localparam logic [3:0] OFF_INPUT_MUX = 4'h4;
   localparam logic [3:0] OFF_MODE_CONTROL = 4'h8;
   localparam logic [3:0] OFF_STATUS = 4'hC;
   localparam int ADDR_WIDTH = 4;
   // Implemented bits; everything else reads as zero.
   localparam logic [31:0] MASK_CLOCK_CONTROL = 32'h0000_9FFF;
   localparam logic [31:0] MASK_INPUT_MUX = 32'h8F8F_0000;
   localparam logic [31:0] MASK_MODE_CONTROL = 32'h0000_00E1;
   localparam logic [31:0] RESET_VALUE = 32'h0000_0000;
   // Field positions in the clock control register.
   localparam int POS_CLK_SOURCE = 15;
   localparam int POS_SAMPLE_TIME = 8;
   localparam int POS_DIVIDER = 0;
   localparam int SAMPLE_TIME_WIDTH = 5;
   localparam int DIVIDER_WIDTH = 8;
   // Field positions in the input mux register.
   localparam int POS_NEG_B = 31;
   localparam int POS_POS_B = 24;
   localparam int POS_NEG_A = 23;
   localparam int POS_POS_A = 16;
   localparam int INPUT_CODE_WIDTH = 4;
   // Field positions in the mode control register.
   localparam int POS_ALT_MODE = 0;
   localparam int POS_TRIGGER = 5;
   localparam int TRIGGER_WIDTH = 3;
   localparam logic [2:0] TRIGGER_AUTO = 3'h7;
   // Status register bits.
   localparam int POS_STAT_SETTING_B = 0;
   localparam int POS_STAT_FAST_RC = 1;
   localparam int POS_STAT_PRESENT = 2;
   // Positive input codes.
   localparam logic [3:0] CODE_OPEN = 4'hF;
   localparam logic [3:0] CODE_INT_REF = 4'hE;
   localparam logic [3:0] CODE_TEMP_SENSOR = 4'hD;
   localparam logic [3:0] CODE_INPUT_12 = 4'hC;
   localparam logic [3:0] CODE_INPUT_6 = 4'h6;
   localparam logic [3:0] CODE_INPUT_8 = 4'h8;
   // Pin counts of the package variants.
   localparam int PINS_SMALL = 28;
   localparam int PINS_LARGE = 44;
   // Bus responses.
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // Sample setting in use.
   typedef enum logic [1:0] {
      SET_A = 2'b01,
      SET_B = 2'b10
   } aci_setting_type;
endpackage

/* File: aci_adc_clock_and_input_select.sv */
// Conversion clock source, divider and input mux select with register slave.
//
// The AXI4-Lite register port and the register offsets were left to the implementer.
`timescale 1ns/1ps
// Functional notes
// - Clock control bit 15 picks fast RC (1) or the bus clock (0) as source.
// - On the bus clock one conversion period is 2*(divider+1) bus periods.
// - The auto sample time is used only while the trigger source is 111.
// - The divider field has no effect while the fast RC source is selected.
// - Unimplemented clock control and input mux bits always read as zero.
// - Bit 31 picks input 1 (1) or the low reference (0) as negative input B.
// - Bits 27-24 pick the positive input code for setting B.
// - Bit 23 picks input 1 (1) or the low reference (0) as negative input A.
// - Bits 19-16 pick the positive input code for setting A.
// - Input 12 needs 44 pins and inputs 6 to 8 are absent with 28 pins.
// - Alternate mode uses A first, then B and A in turn; else always A.
module aci_adc_clock_and_input_select #(
   parameter int PIN_COUNT = 44
) (
   // Clock and reset.
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write address and data.
   input wire logic [aci_pkg::ADDR_WIDTH-1:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response.
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read.
   input wire logic [aci_pkg::ADDR_WIDTH-1:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Oscillator level and sequencer handshake.
   input wire logic internal_fast_rc_osc,
   input wire logic sample_done,
   // Conversion clock and mux outputs.
   output logic conv_clock_tick,
   output logic [3:0] pos_input_sel,
   output logic neg_input_is_an1,
   output logic sample_setting_b,
   output logic pos_input_present,
   output logic [4:0] auto_sample_time,
   output logic auto_sample_active
);
   function automatic logic [31:0] merge_bytes(input logic [31:0] old_value,
         input logic [31:0] new_value, input logic [3:0] strobe,
         input logic [31:0] mask);
      logic [31:0] result;
      result = old_value;
      for (int i = 0; i < 4; i++) begin
         if (strobe[i]) begin
            result[i*8 +: 8] = new_value[i*8 +: 8];
         end
      end
      return result & mask;
   endfunction
   // Inputs 6 to 8 and 12 depend on the package variant.
   function automatic logic code_present(input logic [3:0] code);
      logic present;
      present = 1'b1;
      if (code == aci_pkg::CODE_INPUT_12 &&
            PIN_COUNT != aci_pkg::PINS_LARGE) begin
         present = 1'b0;
      end else if (code >= aci_pkg::CODE_INPUT_6 &&
            code <= aci_pkg::CODE_INPUT_8 &&
            PIN_COUNT == aci_pkg::PINS_SMALL) begin
         present = 1'b0;
      end
      return present;
   endfunction
   logic [31:0] clock_control;
   logic [31:0] input_mux;
   logic [31:0] mode_control;
   logic [aci_pkg::ADDR_WIDTH-1:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic aw_got;
   logic w_got;
   logic [31:0] next_clock_control;
   logic [31:0] next_input_mux;
   logic [31:0] next_mode_control;
   logic [aci_pkg::ADDR_WIDTH-1:0] next_aw_addr;
   logic [31:0] next_w_data;
   logic [3:0] next_w_strb;
   logic next_aw_got;
   logic next_w_got;
   logic next_awready;
   logic next_wready;
   logic next_bvalid;
   logic [1:0] next_bresp;
   logic divider_reload;
   // Write channel: address and data are taken in either order.
   always_comb begin
      next_clock_control = clock_control;
      next_input_mux = input_mux;
      next_mode_control = mode_control;
      next_aw_addr = aw_addr;
      next_w_data = w_data;
      next_w_strb = w_strb;
      next_aw_got = aw_got;
      next_w_got = w_got;
      next_awready = s_axi_awready;
      next_wready = s_axi_wready;
      next_bvalid = s_axi_bvalid;
      next_bresp = s_axi_bresp;
      divider_reload = 1'b0;
      if (s_axi_awvalid && s_axi_awready) begin
         next_aw_addr = s_axi_awaddr;
         next_aw_got = 1'b1;
         next_awready = 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         next_w_data = s_axi_wdata;
         next_w_strb = s_axi_wstrb;
         next_w_got = 1'b1;
         next_wready = 1'b0;
      end
      if (aw_got && w_got && !s_axi_bvalid) begin
         next_aw_got = 1'b0;
         next_w_got = 1'b0;
         next_bvalid = 1'b1;
         next_bresp = aci_pkg::RESP_OKAY;
         if (aw_addr == aci_pkg::OFF_CLOCK_CONTROL) begin
            next_clock_control = merge_bytes(clock_control, w_data, w_strb,
               aci_pkg::MASK_CLOCK_CONTROL);
            divider_reload = 1'b1;
         end else if (aw_addr == aci_pkg::OFF_INPUT_MUX) begin
            next_input_mux = merge_bytes(input_mux, w_data, w_strb,
               aci_pkg::MASK_INPUT_MUX);
         end else if (aw_addr == aci_pkg::OFF_MODE_CONTROL) begin
            next_mode_control = merge_bytes(mode_control, w_data, w_strb,
               aci_pkg::MASK_MODE_CONTROL);
         end else if (aw_addr == aci_pkg::OFF_STATUS) begin
            next_bresp = aci_pkg::RESP_OKAY;
         end else begin
            next_bresp = aci_pkg::RESP_SLVERR;
         end
      end
      if (s_axi_bvalid && s_axi_bready) begin
         next_bvalid = 1'b0;
         next_awready = 1'b1;
         next_wready = 1'b1;
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         clock_control <= aci_pkg::RESET_VALUE;
         input_mux <= aci_pkg::RESET_VALUE;
         mode_control <= aci_pkg::RESET_VALUE;
         aw_addr <= '0;
         w_data <= '0;
         w_strb <= '0;
         aw_got <= 1'b0;
         w_got <= 1'b0;
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= aci_pkg::RESP_OKAY;
      end else begin
         clock_control <= next_clock_control;
         input_mux <= next_input_mux;
         mode_control <= next_mode_control;
         aw_addr <= next_aw_addr;
         w_data <= next_w_data;
         w_strb <= next_w_strb;
         aw_got <= next_aw_got;
         w_got <= next_w_got;
         s_axi_awready <= next_awready;
         s_axi_wready <= next_wready;
         s_axi_bvalid <= next_bvalid;
         s_axi_bresp <= next_bresp;
      end
   end
   logic [31:0] status_word;
   logic [31:0] next_rdata;
   logic [1:0] next_rresp;
   logic next_rvalid;
   logic next_arready;
   // Read channel: one read at a time, answered one cycle after acceptance.
   always_comb begin
      status_word = '0;
      status_word[aci_pkg::POS_STAT_SETTING_B] = sample_setting_b;
      status_word[aci_pkg::POS_STAT_FAST_RC] =
         clock_control[aci_pkg::POS_CLK_SOURCE];
      status_word[aci_pkg::POS_STAT_PRESENT] = pos_input_present;
      next_rdata = s_axi_rdata;
      next_rresp = s_axi_rresp;
      next_rvalid = s_axi_rvalid;
      next_arready = s_axi_arready;
      if (s_axi_arvalid && s_axi_arready) begin
         next_rvalid = 1'b1;
         next_arready = 1'b0;
         next_rresp = aci_pkg::RESP_OKAY;
         if (s_axi_araddr == aci_pkg::OFF_CLOCK_CONTROL) begin
            next_rdata = clock_control;
         end else if (s_axi_araddr == aci_pkg::OFF_INPUT_MUX) begin
            next_rdata = input_mux;
         end else if (s_axi_araddr == aci_pkg::OFF_MODE_CONTROL) begin
            next_rdata = mode_control;
         end else if (s_axi_araddr == aci_pkg::OFF_STATUS) begin
            next_rdata = status_word;
         end else begin
            next_rdata = '0;
            next_rresp = aci_pkg::RESP_SLVERR;
         end
      end else if (s_axi_rvalid && s_axi_rready) begin
         next_rvalid = 1'b0;
         next_arready = 1'b1;
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rdata <= '0;
         s_axi_rresp <= aci_pkg::RESP_OKAY;
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end else begin
         s_axi_rdata <= next_rdata;
         s_axi_rresp <= next_rresp;
         s_axi_rvalid <= next_rvalid;
         s_axi_arready <= next_arready;
      end
   end
   logic [aci_pkg::DIVIDER_WIDTH:0] div_count;
   logic [aci_pkg::DIVIDER_WIDTH:0] next_div_count;
   logic [aci_pkg::DIVIDER_WIDTH:0] period_last;
   logic rc_prev;
   logic next_conv_clock_tick;
   // The oscillator is sampled as a level, so it must run well below aclk.
   always_comb begin
      period_last = {clock_control[aci_pkg::POS_DIVIDER +:
         aci_pkg::DIVIDER_WIDTH], 1'b1};
      next_div_count = div_count;
      next_conv_clock_tick = 1'b0;
      if (clock_control[aci_pkg::POS_CLK_SOURCE]) begin
         next_div_count = '0;
         next_conv_clock_tick = internal_fast_rc_osc && !rc_prev;
      end else if (divider_reload) begin
         next_div_count = '0;
      end else if (div_count >= period_last) begin
         next_div_count = '0;
         next_conv_clock_tick = 1'b1;
      end else begin
         next_div_count = div_count + 1'b1;
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         div_count <= '0;
         rc_prev <= 1'b0;
         conv_clock_tick <= 1'b0;
      end else begin
         div_count <= next_div_count;
         rc_prev <= internal_fast_rc_osc;
         conv_clock_tick <= next_conv_clock_tick;
      end
   end

   aci_pkg::aci_setting_type setting;
   aci_pkg::aci_setting_type next_setting;
   logic [3:0] next_pos_input_sel;
   logic next_neg_input_is_an1;
   logic next_pos_input_present;
   logic [4:0] next_auto_sample_time;
   logic next_auto_sample_active;
   logic alt_mode;

   // Mux setting sequence and the selections it drives.
   always_comb begin
      alt_mode = mode_control[aci_pkg::POS_ALT_MODE];
      next_setting = setting;
      case (setting)
         aci_pkg::SET_A: begin
            if (alt_mode && sample_done) begin
               next_setting = aci_pkg::SET_B;
            end
         end
         aci_pkg::SET_B: begin
            if (!alt_mode || sample_done) begin
               next_setting = aci_pkg::SET_A;
            end
         end
         default: begin
            next_setting = aci_pkg::SET_A;
         end
      endcase
      if (next_setting == aci_pkg::SET_B) begin
         next_pos_input_sel = input_mux[aci_pkg::POS_POS_B +:
            aci_pkg::INPUT_CODE_WIDTH];
         next_neg_input_is_an1 = input_mux[aci_pkg::POS_NEG_B];
      end else begin
         next_pos_input_sel = input_mux[aci_pkg::POS_POS_A +:
            aci_pkg::INPUT_CODE_WIDTH];
         next_neg_input_is_an1 = input_mux[aci_pkg::POS_NEG_A];
      end
      next_pos_input_present = code_present(next_pos_input_sel);
      next_auto_sample_active = mode_control[aci_pkg::POS_TRIGGER +:
         aci_pkg::TRIGGER_WIDTH] == aci_pkg::TRIGGER_AUTO;
      next_auto_sample_time = '0;
      if (next_auto_sample_active) begin
         next_auto_sample_time = clock_control[aci_pkg::POS_SAMPLE_TIME +:
            aci_pkg::SAMPLE_TIME_WIDTH];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         setting <= aci_pkg::SET_A;
         sample_setting_b <= 1'b0;
         pos_input_sel <= '0;
         neg_input_is_an1 <= 1'b0;
         pos_input_present <= 1'b1;
         auto_sample_time <= '0;
         auto_sample_active <= 1'b0;
      end else begin
         setting <= next_setting;
         sample_setting_b <= next_setting == aci_pkg::SET_B;
         pos_input_sel <= next_pos_input_sel;
         neg_input_is_an1 <= next_neg_input_is_an1;
         pos_input_present <= next_pos_input_present;
         auto_sample_time <= next_auto_sample_time;
         auto_sample_active <= next_auto_sample_active;
      end
   end

endmodule // aci_adc_clock_and_input_select

/* File: aci_asserts.sv */
// Checker of bus handshakes, tick shape and mux sequencing.
`timescale 1ns/1ps
module aci_asserts (
   // Clock and reset.
   input wire logic aclk,
   input wire logic aresetn,
   // Bus handshake.
   input wire logic s_axi_awready,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic [aci_pkg::ADDR_WIDTH-1:0] s_axi_araddr,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Converter side.
   input wire logic sample_done,
   input wire logic conv_clock_tick,
   input wire logic sample_setting_b,
   input wire logic [4:0] auto_sample_time,
   input wire logic auto_sample_active
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   tick_single_a: assert property (conv_clock_tick
      |=> !conv_clock_tick)
      else $error("conversion tick lasted two cycles");
   bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready
      |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped early");
   rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped early");
   wr_busy_a: assert property (s_axi_bvalid
      |-> !s_axi_awready && !s_axi_wready)
      else $error("write accepted while response pending");
   rd_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read accepted while data pending");
   auto_gate_a: assert property (!auto_sample_active
      |-> auto_sample_time == 5'h00)
      else $error("sample time shown without auto trigger");
   b_then_a_a: assert property (sample_done && sample_setting_b
      |=> !sample_setting_b)
      else $error("setting B not followed by setting A");
   zero_bits_a: assert property ($rose(s_axi_rvalid) &&
      $past(s_axi_araddr) == aci_pkg::OFF_INPUT_MUX
      |-> (s_axi_rdata & ~aci_pkg::MASK_INPUT_MUX) == 32'h0000_0000)
      else $error("unimplemented mux bits read as one");
   unmapped_a: assert property ($rose(s_axi_rvalid) &&
      ($past(s_axi_araddr) & 4'h3) != 4'h0
      |-> s_axi_rresp == aci_pkg::RESP_SLVERR)
      else $error("unmapped read not refused");
   cover property (conv_clock_tick);
   cover property (sample_done && sample_setting_b);
   cover property (s_axi_bvalid && s_axi_bresp == aci_pkg::RESP_SLVERR);
endmodule // aci_asserts

/* File: tb.sv */
// Self-checking bench of the converter clock and input select block.
`timescale 1ns/1ps
module tb;
   logic aclk = 1'b0, aresetn = 1'b0;
   logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0;
   logic [31:0] s_axi_wdata = 32'h0;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic internal_fast_rc_osc = 1'b0, sample_done = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, conv_clock_tick, neg_input_is_an1, sample_setting_b;
   logic pos_input_present, auto_sample_active, present_small;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   logic [3:0] pos_input_sel;
   logic [4:0] auto_sample_time;
   int fails = 0, cmp_count = 0, cycles = 0;
   aci_adc_clock_and_input_select aci_adc_clock_and_input_select_i (
      .aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .internal_fast_rc_osc, .sample_done, .conv_clock_tick, .pos_input_sel,
      .neg_input_is_an1, .sample_setting_b, .pos_input_present,
      .auto_sample_time, .auto_sample_active);
   // A 28-pin build shares the bus; only its input presence is watched.
   aci_adc_clock_and_input_select #(.PIN_COUNT(28))
         aci_adc_clock_and_input_select_i28 (
      .aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
      .s_axi_awready(), .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid,
      .s_axi_wready(), .s_axi_bresp(), .s_axi_bvalid(), .s_axi_bready,
      .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready(),
      .s_axi_rdata(), .s_axi_rresp(), .s_axi_rvalid(), .s_axi_rready,
      .internal_fast_rc_osc, .sample_done, .conv_clock_tick(),
      .pos_input_sel(), .neg_input_is_an1(), .sample_setting_b(),
      .pos_input_present(present_small), .auto_sample_time(),
      .auto_sample_active());
   always #5 aclk = ~aclk;
   always @(posedge aclk) begin
      cycles++;
      if (cycles == 20000) begin
         fails++;
         conclude();
      end
   end
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fails++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic settle();
      @(posedge aclk);
      #1;
   endtask
   // Address and data are offered together; each is released once taken.
   task automatic wr(input logic [3:0] a, input logic [31:0] d,
         input logic [1:0] er);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      check({30'h0, s_axi_bresp}, {30'h0, er});
      s_axi_bready <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] ed,
         input logic [1:0] er);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      check(s_axi_rdata, ed);
      check({30'h0, s_axi_rresp}, {30'h0, er});
      s_axi_rready <= 1'b0;
   endtask
   task automatic mux_is(input logic [3:0] p, input logic n, input logic b);
      check({26'h0, pos_input_sel, neg_input_is_an1, sample_setting_b},
         {26'h0, p, n, b});
   endtask
   task automatic pulse();
      @(posedge aclk);
      sample_done <= 1'b1;
      @(posedge aclk);
      sample_done <= 1'b0;
      #1;
   endtask
   task automatic t_regs();
      rd(4'h0, 32'h0000_0000, aci_pkg::RESP_OKAY);
      wr(4'h0, 32'hFFFF_FFFF, aci_pkg::RESP_OKAY);
      rd(4'h0, 32'h0000_9FFF, aci_pkg::RESP_OKAY);
      wr(4'h4, 32'hFFFF_FFFF, aci_pkg::RESP_OKAY);
      rd(4'h4, 32'h8F8F_0000, aci_pkg::RESP_OKAY);
      wr(4'h2, 32'h1234_5678, aci_pkg::RESP_SLVERR);
      rd(4'h2, 32'h0000_0000, aci_pkg::RESP_SLVERR);
   endtask
   task automatic t_div(input logic [7:0] d);
      int n;
      wr(4'h0, {24'h0, d}, aci_pkg::RESP_OKAY);
      n = 0;
      do settle(); while (!conv_clock_tick);
      do begin
         settle();
         n++;
      end while (!conv_clock_tick);
      check(n, 2 * (d + 1));
   endtask
   // Divider 5 is loaded too, so a bus-clock tick would show it is used.
   task automatic t_rc();
      int n;
      wr(4'h0, 32'h0000_8005, aci_pkg::RESP_OKAY);
      n = 0;
      repeat (16) begin
         settle();
         if (conv_clock_tick) n++;
      end
      check(n, 0);
      repeat (2) begin
         @(posedge aclk);
         internal_fast_rc_osc <= 1'b1;
         repeat (4) begin
            settle();
            if (conv_clock_tick) n++;
         end
         @(posedge aclk);
         internal_fast_rc_osc <= 1'b0;
         repeat (4) settle();
      end
      check(n, 2);
   endtask
   task automatic t_mux();
      for (int c = 0; c < 15; c++) begin
         wr(4'h4, {12'h0, 4'(c), 16'h0}, aci_pkg::RESP_OKAY);
         settle();
         mux_is(4'(c), 1'b0, 1'b0);
         check({31'h0, pos_input_present}, 32'h1);
         check({31'h0, present_small},
            {31'h0, !((c >= 6 && c <= 8) || c == 12)});
      end
      // The open code is checked as selected and as present in both builds.
      wr(4'h4, 32'h000F_0000, aci_pkg::RESP_OKAY);
      settle();
      mux_is(4'hF, 1'b0, 1'b0);
      check({30'h0, pos_input_present, present_small}, 32'h3);
      wr(4'h4, 32'h8E83_0000, aci_pkg::RESP_OKAY);
      pulse();
      mux_is(4'h3, 1'b1, 1'b0);
      wr(4'h4, 32'h8E03_0000, aci_pkg::RESP_OKAY);
      wr(4'h8, 32'h0000_0001, aci_pkg::RESP_OKAY);
      settle();
      mux_is(4'h3, 1'b0, 1'b0);
      pulse();
      mux_is(4'hE, 1'b1, 1'b1);
      pulse();
      mux_is(4'h3, 1'b0, 1'b0);
      wr(4'h8, 32'h0000_0000, aci_pkg::RESP_OKAY);
   endtask
   task automatic t_auto();
      wr(4'h0, 32'h0000_1500, aci_pkg::RESP_OKAY);
      wr(4'h8, 32'h0000_00C0, aci_pkg::RESP_OKAY);
      settle();
      check({26'h0, auto_sample_active, auto_sample_time}, 32'h00);
      wr(4'h8, 32'h0000_00E0, aci_pkg::RESP_OKAY);
      settle();
      check({26'h0, auto_sample_active, auto_sample_time}, 32'h35);
   endtask
   initial begin
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      t_regs();
      t_div(8'h00);
      t_div(8'h01);
      t_div(8'h05);
      t_rc();
      t_mux();
      t_auto();
      @(posedge aclk);
      aresetn <= 1'b0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      rd(4'h8, 32'h0000_0000, aci_pkg::RESP_OKAY);
      conclude();
   end
endmodule // tb
bind aci_adc_clock_and_input_select aci_asserts aci_asserts_i (
   .aclk, .aresetn, .s_axi_awready, .s_axi_wready, .s_axi_bvalid,
   .s_axi_bready, .s_axi_bresp, .s_axi_araddr, .s_axi_arready, .s_axi_rdata,
   .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sample_done, .conv_clock_tick,
   .sample_setting_b, .auto_sample_time, .auto_sample_active);
